/* File: design/pxc_channels.sv */
// peripheral transfer controller: channel registers, arbitration and data moves
//
// The register addresses and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
// Overview of operation
// - one-direction channel keeps 32-bit current/next pointers and 16-bit current/next counters.
// - two-direction peripheral page holds current/next pairs for transmit and for receive.
// - channel registers sit inside the page of the peripheral they serve.
// - memory to peripheral move takes one clock of bus time.
// - peripheral to memory move takes two clocks.
// - peripheral reached over the bridge side, memory reached as bus master.
// - simultaneous requests resolved by fixed priority, spi receive highest.
// - next pointer/counter pair may be queued while current transfer runs.
// - current count at zero with next nonzero reloads current and clears next.
// - pointer steps by 1, 2 or 4 bytes per byte, half-word, word.
// - end flag at current zero, buffer flag when both counters zero.
module pxc_channels
  import pxc_pkg::*;
#(
  parameter bit HAS_DAC = 1'b1
) (
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic [PXC_AW-1:0]             s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [PXC_AW-1:0]             s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  input  wire logic [PXC_NCH-1:0]            chan_ready,
  input  wire logic [PXC_NCH-1:0][1:0]       chan_size,
  input  wire logic [PXC_NCH-1:0][31:0]      rx_data,
  output logic [PXC_NCH-1:0]                 rx_pull,
  output logic [PXC_NCH-1:0]                 tx_push_q,
  output logic [31:0]                        tx_data_q,
  output logic [PXC_NCH-1:0]                 chan_end,
  output logic [PXC_NCH-1:0]                 chan_buf_done,
  output logic [PXC_NCH-1:0]                 chan_on,
  output pxc_mem_req_t                       mem,
  input  wire logic                          mem_gnt,
  input  wire logic [31:0]                   mem_rdata,
  output logic                               irq
);

  // ---------------- register bus: write path ----------------
  logic                aw_held_q;
  logic [PXC_AW-1:0]   aw_addr_q;
  logic                w_held_q;
  logic [31:0]         w_data_q;
  logic [3:0]          w_strb_q;
  logic                bvalid_q;
  logic [1:0]          bresp_q;
  logic                wr_fire;
  logic                wr_map;
  logic [2:0]          wr_page;
  logic [8:0]          wr_off;
  logic [31:0]         wmask;
  logic [31:0]         wbits;

  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready  = !w_held_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign wr_fire       = aw_held_q && w_held_q && !bvalid_q;
  assign wr_page       = aw_addr_q[PXC_AW-1:PXC_PAGE_LSB];
  assign wr_off        = aw_addr_q[PXC_PAGE_LSB-1:0];
  assign wr_map        = (wr_page < 3'(PXC_NPAGE)) && (wr_off >= PXC_OFF_RPR)
                         && (wr_off <= PXC_OFF_MSK) && (wr_off[1:0] == 2'h0);

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[8*i +: 8] = {8{w_strb_q[i]}};
    end
    wbits = w_data_q & wmask;
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction : merge

  // address and data may arrive in either order
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= '0;
      w_held_q  <= 1'b0;
      w_data_q  <= 32'h0;
      w_strb_q  <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= PXC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_q <= 1'b0;
        w_held_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_map ? PXC_RESP_OKAY : PXC_RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // ---------------- channel state ----------------
  pxc_chan_t           chan_v [PXC_NCH];
  logic [PXC_NCH-1:0]  en_v;
  logic [PXC_NCH-1:0]  present;
  logic [PXC_NCH-1:0]  done;
  logic [PXC_NCH-1:0]  end_ev;
  logic [PXC_NCH-1:0]  buf_ev;
  logic [PXC_NCH-1:0]  req;
  logic [PXC_IW-1:0]   last_q;
  logic                last_v_q;

  for (genvar c = 0; c < PXC_NCH; c++) begin : g_ch
    localparam bit         RX    = PXC_IS_RX[c];
    localparam logic [8:0] O_P   = RX ? PXC_OFF_RPR  : PXC_OFF_TPR;
    localparam logic [8:0] O_C   = RX ? PXC_OFF_RCR  : PXC_OFF_TCR;
    localparam logic [8:0] O_NP  = RX ? PXC_OFF_RNPR : PXC_OFF_TNPR;
    localparam logic [8:0] O_NC  = RX ? PXC_OFF_RNCR : PXC_OFF_TNCR;
    localparam int unsigned B_EN  = RX ? PXC_B_RX_EN  : PXC_B_TX_EN;
    localparam int unsigned B_DIS = RX ? PXC_B_RX_DIS : PXC_B_TX_DIS;

    pxc_chan_t   st_q;
    logic        en_q;
    logic        hit;
    logic [31:0] inc;

    // the dac channel does not exist on the small package
    assign present[c] = !((c == PXC_DAC_CH) && !HAS_DAC);
    assign hit        = wr_fire && wr_map && present[c] && (wr_page == PXC_PAGE_OF[c]);
    assign chan_v[c]  = st_q;
    assign en_v[c]    = en_q;

    always_comb begin
      case (chan_size[c])
        PXC_SZ_BYTE: inc = 32'h0000_0001;
        PXC_SZ_HALF: inc = 32'h0000_0002;
        default:     inc = 32'h0000_0004;
      endcase
    end

    // software write lands last so it wins over a move in the same cycle
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        st_q.ptr  <= PXC_RST_PTR;
        st_q.cnt  <= PXC_RST_CNT;
        st_q.nptr <= PXC_RST_PTR;
        st_q.ncnt <= PXC_RST_CNT;
      end else begin
        if (done[c]) begin
          st_q.ptr <= st_q.ptr + inc;
          if (st_q.cnt != 16'h0) begin
            st_q.cnt <= st_q.cnt - 16'h1;
          end
        end else if (st_q.cnt == 16'h0 && st_q.ncnt != 16'h0) begin
          st_q.ptr  <= st_q.nptr;
          st_q.cnt  <= st_q.ncnt;
          st_q.nptr <= PXC_RST_PTR;
          st_q.ncnt <= PXC_RST_CNT;
        end
        if (hit && wr_off == O_P) begin
          st_q.ptr <= merge(st_q.ptr, w_data_q, wmask);
        end
        if (hit && wr_off == O_C) begin
          st_q.cnt <= (st_q.cnt & ~wmask[15:0]) | (w_data_q[15:0] & wmask[15:0]);
        end
        if (hit && wr_off == O_NP) begin
          st_q.nptr <= merge(st_q.nptr, w_data_q, wmask);
        end
        if (hit && wr_off == O_NC) begin
          st_q.ncnt <= (st_q.ncnt & ~wmask[15:0]) | (w_data_q[15:0] & wmask[15:0]);
        end
      end
    end

    // disable wins when both bits are written together
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        en_q <= 1'b0;
      end else if (hit && wr_off == PXC_OFF_CTL) begin
        if (wbits[B_DIS]) begin
          en_q <= 1'b0;
        end else if (wbits[B_EN]) begin
          en_q <= 1'b1;
        end
      end
    end

    // the served channel sits out one cycle while its ready request drops
    assign req[c] = present[c] && en_q && (st_q.cnt != 16'h0) && chan_ready[c]
                    && !(last_v_q && last_q == PXC_IW'(c));

    assign end_ev[c]        = done[c] && (st_q.cnt == 16'h1);
    assign buf_ev[c]        = end_ev[c] && (st_q.ncnt == 16'h0);
    assign chan_end[c]      = (st_q.cnt == 16'h0);
    assign chan_buf_done[c] = (st_q.cnt == 16'h0) && (st_q.ncnt == 16'h0);
    assign chan_on[c]       = en_q;
  end

  // ---------------- arbitration and moves ----------------
  pxc_state_t          state_q;
  logic [PXC_IW-1:0]   sel_q;
  logic [31:0]         buf_q;
  logic                win_any;
  logic [PXC_IW-1:0]   win_idx;
  logic                win_rx;

  pxc_prio_arb #(
    .N (PXC_NCH)
  ) u_arb (
    .req (req),
    .any (win_any),
    .idx (win_idx)
  );

  assign win_rx = PXC_IS_RX[win_idx];

  // memory side is a plain request/grant master; the grant closes the beat
  always_comb begin
    mem     = '0;
    rx_pull = '0;
    done    = '0;
    case (state_q)
      PXC_IDLE: begin
        if (win_any && win_rx) begin
          rx_pull[win_idx] = 1'b1;
        end else if (win_any) begin
          mem.req  = 1'b1;
          mem.we   = 1'b0;
          mem.size = chan_size[win_idx];
          mem.addr = chan_v[win_idx].ptr;
          done[win_idx] = mem_gnt;
        end
      end
      PXC_RX_STORE: begin
        mem.req   = 1'b1;
        mem.we    = 1'b1;
        mem.size  = chan_size[sel_q];
        mem.addr  = chan_v[sel_q].ptr;
        mem.wdata = buf_q;
        done[sel_q] = mem_gnt;
      end
      default: begin
        mem = '0;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= PXC_IDLE;
      sel_q   <= '0;
      buf_q   <= 32'h0;
    end else begin
      case (state_q)
        PXC_IDLE: begin
          if (win_any && win_rx) begin
            sel_q   <= win_idx;
            buf_q   <= rx_data[win_idx];
            state_q <= PXC_RX_STORE;
          end
        end
        PXC_RX_STORE: begin
          if (mem_gnt) begin
            state_q <= PXC_IDLE;
          end
        end
        default: begin
          state_q <= PXC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      last_q   <= '0;
      last_v_q <= 1'b0;
    end else begin
      last_v_q <= |done;
      if (state_q == PXC_RX_STORE) begin
        last_q <= sel_q;
      end else begin
        last_q <= win_idx;
      end
    end
  end

  // transmit data reaches the holding register one cycle after the fetch
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_push_q <= '0;
      tx_data_q <= 32'h0;
    end else begin
      tx_push_q <= done & ~PXC_IS_RX;
      if (|(done & ~PXC_IS_RX)) begin
        tx_data_q <= mem_rdata;
      end
    end
  end

  // ---------------- events and interrupt ----------------
  logic [PXC_NPAGE-1:0][3:0] evt_q;
  logic [PXC_NPAGE-1:0][3:0] msk_q;
  logic [PXC_NPAGE-1:0][3:0] ev_set;

  always_comb begin
    ev_set = '0;
    for (int p = 0; p < PXC_NPAGE; p++) begin
      for (int c = 0; c < PXC_NCH; c++) begin
        if (PXC_PAGE_OF[c] == 3'(p)) begin
          if (PXC_IS_RX[c]) begin
            ev_set[p][PXC_E_RX_END]  = ev_set[p][PXC_E_RX_END] | end_ev[c];
            ev_set[p][PXC_E_RX_FULL] = ev_set[p][PXC_E_RX_FULL] | buf_ev[c];
          end else begin
            ev_set[p][PXC_E_TX_END]  = ev_set[p][PXC_E_TX_END] | end_ev[c];
            ev_set[p][PXC_E_TX_EMPT] = ev_set[p][PXC_E_TX_EMPT] | buf_ev[c];
          end
        end
      end
    end
  end

  // a new event beats a clear in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      evt_q <= '0;
      msk_q <= '0;
    end else begin
      for (int p = 0; p < PXC_NPAGE; p++) begin
        if (wr_fire && wr_map && wr_page == 3'(p) && wr_off == PXC_OFF_EVT) begin
          evt_q[p] <= (evt_q[p] & ~wbits[3:0]) | ev_set[p];
        end else begin
          evt_q[p] <= evt_q[p] | ev_set[p];
        end
        if (wr_fire && wr_map && wr_page == 3'(p) && wr_off == PXC_OFF_MSK) begin
          msk_q[p] <= (msk_q[p] & ~wmask[3:0]) | (w_data_q[3:0] & wmask[3:0]);
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(evt_q & msk_q);
    end
  end

  // ---------------- register bus: read path ----------------
  logic [2:0]  rd_page;
  logic [8:0]  rd_off;
  logic        rd_map;
  logic [31:0] rd_word;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;

  assign rd_page = s_axi_araddr[PXC_AW-1:PXC_PAGE_LSB];
  assign rd_off  = s_axi_araddr[PXC_PAGE_LSB-1:0];
  assign rd_map  = (rd_page < 3'(PXC_NPAGE)) && (rd_off >= PXC_OFF_RPR)
                   && (rd_off <= PXC_OFF_MSK) && (rd_off[1:0] == 2'h0);

  always_comb begin
    rd_word = 32'h0;
    for (int c = 0; c < PXC_NCH; c++) begin
      if (present[c] && PXC_PAGE_OF[c] == rd_page) begin
        if (PXC_IS_RX[c]) begin
          case (rd_off)
            PXC_OFF_RPR:  rd_word = rd_word | chan_v[c].ptr;
            PXC_OFF_RCR:  rd_word = rd_word | {16'h0, chan_v[c].cnt};
            PXC_OFF_RNPR: rd_word = rd_word | chan_v[c].nptr;
            PXC_OFF_RNCR: rd_word = rd_word | {16'h0, chan_v[c].ncnt};
            PXC_OFF_STS: begin
              rd_word[PXC_B_RX_ON]   = en_v[c];
              rd_word[PXC_B_RX_END]  = chan_end[c];
              rd_word[PXC_B_RX_FULL] = chan_buf_done[c];
            end
            default: rd_word = rd_word;
          endcase
        end else begin
          case (rd_off)
            PXC_OFF_TPR:  rd_word = rd_word | chan_v[c].ptr;
            PXC_OFF_TCR:  rd_word = rd_word | {16'h0, chan_v[c].cnt};
            PXC_OFF_TNPR: rd_word = rd_word | chan_v[c].nptr;
            PXC_OFF_TNCR: rd_word = rd_word | {16'h0, chan_v[c].ncnt};
            PXC_OFF_STS: begin
              rd_word[PXC_B_TX_ON]   = en_v[c];
              rd_word[PXC_B_TX_END]  = chan_end[c];
              rd_word[PXC_B_TX_EMPT] = chan_buf_done[c];
            end
            default: rd_word = rd_word;
          endcase
        end
      end
    end
    for (int p = 0; p < PXC_NPAGE; p++) begin
      if (rd_page == 3'(p) && rd_off == PXC_OFF_EVT) begin
        rd_word = {28'h0, evt_q[p]};
      end
      if (rd_page == 3'(p) && rd_off == PXC_OFF_MSK) begin
        rd_word = {28'h0, msk_q[p]};
      end
    end
  end

  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0;
      rresp_q  <= PXC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_map ? rd_word : 32'h0;
      rresp_q  <= rd_map ? PXC_RESP_OKAY : PXC_RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule : pxc_channels

/* File: design/pxc_pkg.sv */
// constants, layouts and carrier types for the peripheral transfer controller
package pxc_pkg;

  localparam int unsigned PXC_NCH   = 10;
  localparam int unsigned PXC_NPAGE = 6;
  localparam int unsigned PXC_AW    = 12;
  localparam int unsigned PXC_IW    = 4;

  // register offsets inside each peripheral page
  localparam logic [8:0] PXC_OFF_RPR  = 9'h100;
  localparam logic [8:0] PXC_OFF_RCR  = 9'h104;
  localparam logic [8:0] PXC_OFF_TPR  = 9'h108;
  localparam logic [8:0] PXC_OFF_TCR  = 9'h10c;
  localparam logic [8:0] PXC_OFF_RNPR = 9'h110;
  localparam logic [8:0] PXC_OFF_RNCR = 9'h114;
  localparam logic [8:0] PXC_OFF_TNPR = 9'h118;
  localparam logic [8:0] PXC_OFF_TNCR = 9'h11c;
  localparam logic [8:0] PXC_OFF_CTL  = 9'h120;
  localparam logic [8:0] PXC_OFF_STS  = 9'h124;
  localparam logic [8:0] PXC_OFF_EVT  = 9'h128;
  localparam logic [8:0] PXC_OFF_MSK  = 9'h12c;

  // page index is address bits from this position upward
  localparam int unsigned PXC_PAGE_LSB = 9;

  // transfer control bits (write-only)
  localparam int unsigned PXC_B_RX_EN  = 0;
  localparam int unsigned PXC_B_RX_DIS = 1;
  localparam int unsigned PXC_B_TX_EN  = 8;
  localparam int unsigned PXC_B_TX_DIS = 9;

  // transfer status bits
  localparam int unsigned PXC_B_RX_ON   = 0;
  localparam int unsigned PXC_B_TX_ON   = 8;
  localparam int unsigned PXC_B_RX_END  = 16;
  localparam int unsigned PXC_B_RX_FULL = 17;
  localparam int unsigned PXC_B_TX_END  = 18;
  localparam int unsigned PXC_B_TX_EMPT = 19;

  // event / mask layout
  localparam int unsigned PXC_E_RX_END  = 0;
  localparam int unsigned PXC_E_RX_FULL = 1;
  localparam int unsigned PXC_E_TX_END  = 2;
  localparam int unsigned PXC_E_TX_EMPT = 3;

  localparam logic [31:0] PXC_RST_PTR = 32'h0000_0000;
  localparam logic [15:0] PXC_RST_CNT = 16'h0000;
  localparam logic [3:0]  PXC_RST_EVT = 4'h0;

  // channel map, index = priority (higher wins)
  localparam logic [PXC_NCH-1:0] PXC_IS_RX = 10'h3e0;
  localparam logic [2:0] PXC_PAGE_OF [PXC_NCH] =
    '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h0, 3'h1, 3'h2, 3'h5, 3'h4};
  localparam int unsigned PXC_DAC_CH = 3;

  localparam logic [1:0] PXC_SZ_BYTE = 2'h0;
  localparam logic [1:0] PXC_SZ_HALF = 2'h1;

  localparam logic [1:0] PXC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] PXC_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [31:0] ptr;
    logic [15:0] cnt;
    logic [31:0] nptr;
    logic [15:0] ncnt;
  } pxc_chan_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [1:0]  size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } pxc_mem_req_t;

  typedef enum logic [0:0] {
    PXC_IDLE,
    PXC_RX_STORE
  } pxc_state_t;

endpackage : pxc_pkg

/* File: design/pxc_prio_arb.sv */
// fixed priority picker, highest index wins
`timescale 1ns/1ps
module pxc_prio_arb
  import pxc_pkg::*;
#(
  parameter int unsigned N = PXC_NCH
) (
  input  wire logic [N-1:0]      req,
  output logic                   any,
  output logic [PXC_IW-1:0]      idx
);

  always_comb begin
    any = 1'b0;
    idx = '0;
    for (int i = 0; i < N; i++) begin
      if (req[i]) begin
        any = 1'b1;
        idx = PXC_IW'(i);
      end
    end
  end

endmodule : pxc_prio_arb

/* File: dv/pxc_channels_sva.sv */
// port-level assertions for the transfer controller
`timescale 1ns/1ps
module pxc_channels_sva
  import pxc_pkg::*;
(
  input wire logic               clk,
  input wire logic               rst,
  input wire logic [PXC_NCH-1:0] chan_ready,
  input wire logic [PXC_NCH-1:0] rx_pull,
  input wire logic [PXC_NCH-1:0] tx_push_q,
  input wire logic [PXC_NCH-1:0] chan_end,
  input wire logic [PXC_NCH-1:0] chan_buf_done,
  input wire logic [PXC_NCH-1:0] chan_on,
  input wire pxc_mem_req_t       mem,
  input wire logic               mem_gnt
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_pull;
    |rx_pull;
  endsequence
  sequence s_store;
    mem.req && mem.we;
  endsequence
  sequence s_store_held;
    mem.req && mem.we && $stable(mem.addr) && $stable(mem.wdata);
  endsequence
  sequence s_fetch;
    mem.req && !mem.we && mem_gnt;
  endsequence
  chk_rx_two_step: assert property (s_pull |=> s_store)
    else $error("receive pull not followed by memory store");
  chk_rx_no_bus: assert property (s_pull |-> !mem.req)
    else $error("memory request during receive pull");
  chk_store_hold: assert property ((s_store and !mem_gnt) |=> s_store_held)
    else $error("store request changed before grant");
  chk_tx_push_next: assert property (s_fetch |=> $onehot(tx_push_q))
    else $error("granted fetch not pushed next cycle");
  chk_push_cause: assert property (|tx_push_q |-> $past(mem.req && !mem.we && mem_gnt))
    else $error("transmit push without granted fetch");
  chk_single_move: assert property ($onehot0(tx_push_q) && $onehot0(rx_pull))
    else $error("more than one channel served at once");
  chk_pull_gate: assert property ((rx_pull & ~(chan_on & ~chan_end & chan_ready)) == '0)
    else $error("pull from channel not eligible");
  chk_buf_end: assert property ((chan_buf_done & ~chan_end) == '0)
    else $error("buffer flag without end flag");
endmodule : pxc_channels_sva
bind pxc_channels pxc_channels_sva sva (.*);

/* File: dv/pxc_mem_model.sv */
// memory side model: random grant stalls and address-derived read data
`timescale 1ns/1ps
module pxc_mem_model
  import pxc_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   rst,
  input  pxc_mem_req_t mem,
  output logic        mem_gnt,
  output logic [31:0] mem_rdata
);
  logic [31:0] word;
  assign word = {mem.addr[15:0], ~mem.addr[15:0]};
  // grant stalls about one beat in three, so the engine must hold its request
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mem_gnt <= 1'b0;
    end else begin
      mem_gnt <= ($urandom % 3) != 0;
    end
  end
  // data only valid on a granted read, inverse otherwise to expose stale capture
  assign mem_rdata = (mem.req && !mem.we && mem_gnt) ? word : ~word;
endmodule : pxc_mem_model

/* File: dv/testbench.sv */
// bench: registers, prioritised moves with reload, interrupt and disable
`timescale 1ns/1ps
module testbench;
  import pxc_pkg::*;
  logic                     clk, rst, irq, mem_gnt;
  logic [PXC_AW-1:0]        s_axi_awaddr, s_axi_araddr;
  logic                     s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic                     s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                     s_axi_rvalid, s_axi_rready, seen;
  logic [31:0]              s_axi_wdata, s_axi_rdata, tx_data_q, mem_rdata, ta, rv;
  logic [3:0]               s_axi_wstrb;
  logic [1:0]               s_axi_bresp, s_axi_rresp, rr;
  logic [PXC_NCH-1:0]       chan_ready, rx_pull, tx_push_q, chan_end, chan_buf_done, chan_on;
  logic [PXC_NCH-1:0][1:0]  chan_size;
  logic [PXC_NCH-1:0][31:0] rx_data;
  pxc_mem_req_t             mem;
  logic [31:0]              rxq[$];
  int                       mismatches, checked, tn, rn, pn;

  pxc_channels dut (.*);
  pxc_mem_model far (.*);

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk32(input string n, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk32

  task automatic chk1(input string n, input logic e, input logic s);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s expected %b seen %b", n, e, s);
    end
  endtask : chk1

  function automatic logic [11:0] ad(input int p, input logic [8:0] o);
    return {3'(p), o};
  endfunction : ad

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic ta_ok, w_ok;
    ta_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clk);
      ta_ok |= s_axi_awready;
      w_ok |= s_axi_wready;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(ta_ok && w_ok));
    do @(posedge clk); while (!s_axi_bvalid);
    rr = s_axi_bresp;
  endtask : wr

  task automatic rd(input logic [11:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (!s_axi_rvalid);
    rv = s_axi_rdata;
    rr = s_axi_rresp;
  endtask : rd

  task automatic end_of_test;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test

  // reference model: expected addresses from pointer steps, queued receive words
  always @(posedge clk) begin
    if (!rst && !seen && (|rx_pull || mem.req)) begin
      seen = 1'b1;
      chk1("first served rx", 1'b1, rx_pull[8]);
    end
    if (!rst && mem.req && !mem.we && mem_gnt) begin
      ta = (tn < 3) ? 32'h1000 + 2 * tn : 32'h2000 + 2 * (tn - 3);
      chk32("tx addr", ta, mem.addr);
      tn++;
    end
    if (tx_push_q[4]) begin
      chk32("tx data", {ta[15:0], ~ta[15:0]}, tx_data_q);
      pn++;
    end
    if (rx_pull[8]) begin
      rxq.push_back(rx_data[8]);
      rx_data[8] <= $urandom;
    end
    if (!rst && mem.req && mem.we && mem_gnt) begin
      chk32("rx addr", 32'h3000 + 4 * rn, mem.addr);
      chk32("rx data", rxq.pop_front(), mem.wdata);
      rn++;
    end
  end

  initial begin
    #(100 * 20000);
    mismatches++;
    end_of_test;
  end

  initial begin
    void'($urandom(32'h53e6));
    {rst, s_axi_bready, s_axi_rready} = 3'b111;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, seen} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    chan_ready = '0;
    chan_size = '0;
    chan_size[4] = PXC_SZ_HALF;
    chan_size[8] = 2'h2;
    rx_data = '0;
    rx_data[8] = $urandom;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(ad(4, PXC_OFF_TCR));
    chk32("tx cnt reset", 32'h0, rv);
    rd(ad(7, PXC_OFF_RPR));
    chk32("unmapped resp", {30'h0, PXC_RESP_SLVERR}, {30'h0, rr});
    $display("test registers done");
    wr(ad(4, PXC_OFF_TPR), 32'h1000);
    chk32("wr resp", {30'h0, PXC_RESP_OKAY}, {30'h0, rr});
    wr(ad(4, PXC_OFF_TCR), 32'h3);
    wr(ad(4, PXC_OFF_TNPR), 32'h2000);
    wr(ad(4, PXC_OFF_TNCR), 32'h2);
    wr(ad(5, PXC_OFF_RPR), 32'h3000);
    wr(ad(5, PXC_OFF_RCR), 32'h4);
    wr(ad(5, PXC_OFF_MSK), 32'h1 << PXC_E_RX_FULL);
    wr(ad(4, PXC_OFF_CTL), 32'h1 << PXC_B_TX_EN);
    wr(ad(5, PXC_OFF_CTL), 32'h1 << PXC_B_RX_EN);
    chk1("tx on", 1'b1, chan_on[4]);
    rd(ad(5, PXC_OFF_STS));
    chk1("rx on status", 1'b1, rv[PXC_B_RX_ON]);
    chan_ready[4] <= 1'b1;
    chan_ready[8] <= 1'b1;
    for (int i = 0; i < 3000 && !(tn == 5 && rn == 4); i++) @(posedge clk);
    repeat (20) @(posedge clk);
    chk32("tx moves", 32'd5, tn);
    chk32("rx moves", 32'd4, rn);
    chk32("tx pushes", 32'd5, pn);
    chk1("tx end", 1'b1, chan_end[4]);
    chk1("tx buf done", 1'b1, chan_buf_done[4]);
    chk1("rx buf done", 1'b1, chan_buf_done[8]);
    rd(ad(4, PXC_OFF_TPR));
    chk32("tx ptr end", 32'h2004, rv);
    rd(ad(4, PXC_OFF_TNCR));
    chk32("tx next cleared", 32'h0, rv);
    $display("test moves done");
    chk1("irq raised", 1'b1, irq);
    wr(ad(5, PXC_OFF_MSK), 32'h0);
    repeat (2) @(posedge clk);
    chk1("irq masked", 1'b0, irq);
    wr(ad(5, PXC_OFF_MSK), 32'h1 << PXC_E_RX_FULL);
    repeat (2) @(posedge clk);
    chk1("irq unmasked", 1'b1, irq);
    wr(ad(5, PXC_OFF_EVT), 32'h1 << PXC_E_RX_FULL);
    repeat (2) @(posedge clk);
    chk1("irq cleared", 1'b0, irq);
    $display("test interrupt done");
    wr(ad(4, PXC_OFF_CTL), 32'h1 << PXC_B_TX_DIS);
    rd(ad(4, PXC_OFF_STS));
    chk1("tx off status", 1'b0, rv[PXC_B_TX_ON]);
    chk1("tx off", 1'b0, chan_on[4]);
    $display("test disable done");
    end_of_test;
  end
endmodule : testbench
